// File: rtl/sdc_drv_ctrl.sv
// Driver control word decoder with serial capture and step input qualification.
//
// Contract
// - Step-input-disable set: step pins ignored, coil currents come from word.
// - Step-input-disable clear: step pins used, word configures step interface.
// - Direct mode bit 17 is coil A sign; 1 reverses current.
// - Direct mode bits 16..9 are coil A magnitude, bit 16 MSB.
// - Direct mode bit 8 is coil B sign; 1 reverses current.
// - Direct mode bits 7..0 are coil B magnitude, bit 7 MSB.
// - Step mode bit 9 enables interpolation into 16 microsteps per step.
// - Step mode bit 8: 0 rising edges only, 1 both edges.
// - Step mode bits 3..0: 0 gives 256, each step halves, 8 fullstep.
// - Word targets this register when bits 19 and 18 are zero.
// - Last 20 bits shifted in are loaded at chip select rise.
`timescale 1ns/1ps
`default_nettype none
module sdc_drv_ctrl
  import sdc_pkg::*;
#(
  parameter int unsigned WORD_W = SDC_WORD_W
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Serial pins
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic cs_b_i,
  // Mode bit from the driver configuration register
  input wire logic step_input_disable_i,
  // Step and direction pins
  input wire logic step_i,
  input wire logic dir_i,
  // Coil current outputs
  output logic coil_a_sign_o,
  output logic [7:0] coil_a_magnitude_o,
  output logic coil_b_sign_o,
  output logic [7:0] coil_b_magnitude_o,
  // Step interface configuration
  output logic step_interpolation_enable_o,
  output logic both_edges_step_o,
  output logic [3:0] microstep_resolution_o,
  output logic [8:0] microsteps_per_quarter_o,
  // Qualified step events
  output logic step_event_o,
  output logic step_dir_o,
  output logic [4:0] step_mult_o
);
  // ==========================================================================
  // Pin synchronisers
  logic [4:0] pin_s1_q, pin_s2_q;
  logic sck_s, sdi_s, cs_s, step_s, dir_s;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_q <= 5'h01;
      pin_s2_q <= 5'h01;
    end else begin
      pin_s1_q <= {dir_i, step_i, sdi_i, sck_i, cs_b_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign {dir_s, step_s, sdi_s, sck_s, cs_s} = pin_s2_q;

  // ==========================================================================
  // Serial capture
  logic [WORD_W-1:0] rx_word;
  logic rx_valid;

  sdc_spi_shift #(
    .WORD_W(WORD_W)
  ) u_shift (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .sck_i(sck_s),
    .sdi_i(sdi_s),
    .cs_b_i(cs_s),
    .word_o(rx_word),
    .word_valid_o(rx_valid)
  );

  // ==========================================================================
  // Control word register
  logic [WORD_W-1:0] ctrl_q, ctrl_d;
  logic hit;

  always_comb begin
    hit = (rx_word[SDC_ADDR_HI:SDC_ADDR_LO] == SDC_ADDR_DRV_CTRL);
    ctrl_d = ctrl_q;
    if (rx_valid && hit) begin
      ctrl_d = rx_word;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= SDC_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ==========================================================================
  // Field decode
  logic direct;
  assign direct = step_input_disable_i;

  always_comb begin
    // Direct mode: coil currents straight from the word.
    coil_a_sign_o = direct & ctrl_q[SDC_A_SIGN_BIT];
    coil_a_magnitude_o = direct ? ctrl_q[SDC_A_MAG_HI:SDC_A_MAG_LO] : 8'h00;
    coil_b_sign_o = direct & ctrl_q[SDC_B_SIGN_BIT];
    coil_b_magnitude_o = direct ? ctrl_q[SDC_B_MAG_HI:SDC_B_MAG_LO] : 8'h00;
    // Step mode: same word read as step interface configuration.
    step_interpolation_enable_o = !direct & ctrl_q[SDC_INTERP_BIT];
    both_edges_step_o = !direct & ctrl_q[SDC_BOTH_EDGES_BIT];
    microstep_resolution_o = direct ? 4'h0 : ctrl_q[SDC_RES_HI:SDC_RES_LO];
    // Codes above fullstep are clamped to fullstep.
    if (microstep_resolution_o > SDC_RES_FULL) begin
      microsteps_per_quarter_o = 9'h001;
    end else begin
      microsteps_per_quarter_o = SDC_USTEP_MAX >> microstep_resolution_o;
    end
  end

  // ==========================================================================
  // Step edge qualification
  logic step_prev_q, step_prev_d;
  logic ev_q, ev_d, dir_q, dir_d;
  logic [4:0] mult_q, mult_d;

  always_comb begin
    step_prev_d = step_s;
    ev_d = 1'b0;
    dir_d = dir_q;
    mult_d = mult_q;
    if (!direct) begin
      if ((step_s && !step_prev_q) || (both_edges_step_o && !step_s && step_prev_q)) begin
        ev_d = 1'b1;
        dir_d = dir_s;
        mult_d = step_interpolation_enable_o ? SDC_INTERP_MULT : 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_prev_q <= 1'b0;
      ev_q <= 1'b0;
      dir_q <= 1'b0;
      mult_q <= 5'h01;
    end else begin
      step_prev_q <= step_prev_d;
      ev_q <= ev_d;
      dir_q <= dir_d;
      mult_q <= mult_d;
    end
  end

  assign step_event_o = ev_q;
  assign step_dir_o = dir_q;
  assign step_mult_o = mult_q;

  // ==========================================================================
  // Checks
  a_direct_no_step: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $past(direct) |-> !step_event_o)
    else $error("Step event while step input disabled.");

  a_direct_cfg_off: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    direct |-> (!step_interpolation_enable_o && !both_edges_step_o &&
      microstep_resolution_o == 4'h0))
    else $error("Step configuration leaks in direct mode.");

  a_coil_a_map: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    direct |-> (coil_a_magnitude_o == ctrl_q[16:9] && coil_a_sign_o == ctrl_q[17]))
    else $error("Coil A fields wrong.");

  a_coil_a_mag: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !direct |-> coil_a_magnitude_o == 8'h00)
    else $error("Coil A magnitude leaks in step mode.");

  a_coil_b_map: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    direct |-> (coil_b_magnitude_o == ctrl_q[7:0] && coil_b_sign_o == ctrl_q[8]))
    else $error("Coil B fields wrong.");

  a_step_coil_off: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !direct |-> (!coil_a_sign_o && !coil_b_sign_o && coil_b_magnitude_o == 8'h00))
    else $error("Coil B current leaks in step mode.");

  a_step_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (!direct && step_s && !step_prev_q) |=> (step_event_o && step_dir_o == $past(dir_s)))
    else $error("Rising step edge missed.");

  a_step_fall: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (!step_s && step_prev_q) |=> (step_event_o == $past(!direct && both_edges_step_o)))
    else $error("Falling edge handling wrong.");

  // A qualified edge gives exactly one event cycle while the pin level holds.
  sequence s_step_edge;
    !direct && ((step_s && !step_prev_q) || (both_edges_step_o && !step_s && step_prev_q));
  endsequence

  a_step_pulse_once: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_step_edge |=> step_event_o ##1 !step_event_o)
    else $error("Step event is not a single cycle.");

  a_interp_mult: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    step_event_o |-> step_mult_o == ($past(ctrl_q[9]) ? 5'h10 : 5'h01))
    else $error("Interpolation multiplier wrong.");

  a_res_count: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (!direct && ctrl_q[3:0] == 4'h8) |-> microsteps_per_quarter_o == 9'h001)
    else $error("Fullstep count wrong.");

  a_res_finest: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (!direct && ctrl_q[3:0] == 4'h0) |-> microsteps_per_quarter_o == 9'h100)
    else $error("Finest resolution count wrong.");

  a_addr_select: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (rx_valid && rx_word[19:18] != 2'h0) |=> $stable(ctrl_q))
    else $error("Foreign word loaded.");

  // A complete word addressed to this register replaces the whole control word.
  sequence s_word_hit;
    rx_valid && rx_word[19:18] == 2'h0;
  endsequence

  a_ctrl_load: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s_word_hit |=> ctrl_q == $past(rx_word))
    else $error("Addressed word not loaded.");
endmodule
`default_nettype wire

// File: rtl/sdc_pkg.sv
// Package of constants for the stepper driver control word decoder.
package sdc_pkg;
  // ==========================================================================
  // Word layout
  localparam int unsigned SDC_WORD_W = 20;
  localparam int unsigned SDC_ADDR_HI = 19;
  localparam int unsigned SDC_ADDR_LO = 18;
  localparam logic [1:0] SDC_ADDR_DRV_CTRL = 2'h0;
  localparam int unsigned SDC_A_SIGN_BIT = 17;
  localparam int unsigned SDC_A_MAG_HI = 16;
  localparam int unsigned SDC_A_MAG_LO = 9;
  localparam int unsigned SDC_B_SIGN_BIT = 8;
  localparam int unsigned SDC_B_MAG_HI = 7;
  localparam int unsigned SDC_B_MAG_LO = 0;
  localparam int unsigned SDC_INTERP_BIT = 9;
  localparam int unsigned SDC_BOTH_EDGES_BIT = 8;
  localparam int unsigned SDC_RES_HI = 3;
  localparam int unsigned SDC_RES_LO = 0;
  // ==========================================================================
  // Reset values and limits
  localparam logic [19:0] SDC_CTRL_RESET = 20'h00000;
  localparam logic [3:0] SDC_RES_FULL = 4'h8;
  localparam logic [8:0] SDC_USTEP_MAX = 9'h100;
  localparam logic [4:0] SDC_INTERP_MULT = 5'h10;
endpackage

// File: rtl/sdc_spi_shift.sv
// Serial shift register that captures the last word before chip select rises.
`timescale 1ns/1ps
`default_nettype none
module sdc_spi_shift
  import sdc_pkg::*;
#(
  parameter int unsigned WORD_W = SDC_WORD_W
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Synchronised serial inputs
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic cs_b_i,
  // Word output
  output logic [WORD_W-1:0] word_o,
  output logic word_valid_o
);
  logic [WORD_W-1:0] shift_q, shift_d;
  logic sck_q, sck_d, cs_q, cs_d;
  logic [WORD_W-1:0] word_q, word_d;
  logic valid_q, valid_d;

  always_comb begin
    shift_d = shift_q;
    sck_d = sck_i;
    cs_d = cs_b_i;
    word_d = word_q;
    valid_d = 1'b0;
    // Surplus leading bits fall out of the top; only the last WORD_W remain.
    if (!cs_b_i && sck_i && !sck_q) begin
      shift_d = {shift_q[WORD_W-2:0], sdi_i};
    end
    if (cs_b_i && !cs_q) begin
      word_d = shift_q;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_q <= '0;
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      word_q <= '0;
      valid_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      sck_q <= sck_d;
      cs_q <= cs_d;
      word_q <= word_d;
      valid_q <= valid_d;
    end
  end

  assign word_o = word_q;
  assign word_valid_o = valid_q;

  a_latch_on_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (cs_b_i && !cs_q) |=> (valid_q && word_q == $past(shift_q)))
    else $error("Word not latched at chip select rise.");
endmodule
`default_nettype wire

// File: tb/sdc_host_model.sv
// Serial host model that writes control words into the decoder.
`timescale 1ns/1ps
`default_nettype none
module sdc_host_model (
  // Clock
  input wire logic clk_i,
  // Serial pins
  output logic sck_o,
  output logic sdi_o,
  output logic cs_b_o
);
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    cs_b_o = 1'b1;
  end
  // ==========================================================================
  // Word transfer
  // Sends n bits MSB first; the clock stands still outside a frame.
  task automatic send(input logic [23:0] w, input int n);
    @(posedge clk_i);
    cs_b_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o <= w[i];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_b_o <= 1'b1;
    // The released data line no longer shows the last bit.
    sdi_o <= ~sdi_o;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: tb/stepper_driver_control_word_tb_top.sv
// Self-checking testbench for the control word decoder.
`timescale 1ns/1ps
`default_nettype none
module stepper_driver_control_word_tb_top;
  import sdc_pkg::*;
  typedef struct packed {logic m; logic [19:0] w; logic [19:0] e;} sdc_row_t;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic mode = 1'b0;
  logic step_i = 1'b0;
  logic dir_i = 1'b1;
  logic sck, sdi, cs_b, a_s, b_s, interp, both_edges, ev, sdir;
  logic [7:0] a_m, b_m;
  logic [3:0] res_code;
  logic [8:0] mpq;
  logic [4:0] mult;
  int failures = 0;
  int cmp_count = 0;
  int ev_cnt = 0;
  wire logic [19:0] obs = mode ? {2'h0, a_s, a_m, b_s, b_m} :
    {5'h0, interp, both_edges, res_code, mpq};
  // Direct rows: magnitudes within 248; step rows: reserved bits zero, codes up to 8.
  sdc_row_t rows [12] = '{'{1'b1, 20'h3f001, 20'h3f001}, '{1'b1, 20'h001f8, 20'h001f8},
    '{1'b1, 20'h1f000, 20'h1f000}, '{1'b0, 20'h00200, 20'h04100},
    '{1'b0, 20'h00101, 20'h02280}, '{1'b0, 20'h00002, 20'h00440},
    '{1'b0, 20'h00003, 20'h00620}, '{1'b0, 20'h00004, 20'h00810},
    '{1'b0, 20'h00005, 20'h00a08}, '{1'b0, 20'h00006, 20'h00c04},
    '{1'b0, 20'h00007, 20'h00e02}, '{1'b0, 20'h00308, 20'h07001}};
  always #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (ev === 1'b1) ev_cnt <= ev_cnt + 1;
  sdc_host_model u_host (.clk_i(sys_clk_i), .sck_o(sck), .sdi_o(sdi), .cs_b_o(cs_b));
  sdc_drv_ctrl u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sck_i(sck), .sdi_i(sdi),
    .cs_b_i(cs_b), .step_input_disable_i(mode), .step_i(step_i), .dir_i(dir_i),
    .coil_a_sign_o(a_s), .coil_a_magnitude_o(a_m), .coil_b_sign_o(b_s),
    .coil_b_magnitude_o(b_m), .step_interpolation_enable_o(interp),
    .both_edges_step_o(both_edges), .microstep_resolution_o(res_code),
    .microsteps_per_quarter_o(mpq), .step_event_o(ev), .step_dir_o(sdir),
    .step_mult_o(mult));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [23:0] w, input int n);
    u_host.send(w, n);
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  // Toggles the step pin n times and returns the events counted.
  task automatic steps(input int n, output int cnt);
    int base;
    @(posedge sys_clk_i);
    base = ev_cnt;
    for (int i = 0; i < n; i++) begin
      step_i <= ~step_i;
      repeat (5) @(posedge sys_clk_i);
    end
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    cnt = ev_cnt - base;
  endtask
  task automatic final_report();
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    int n;
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(negedge sys_clk_i);
    chk(obs, 20'h00100);
    chk(20'(mult), 20'h1);
    foreach (rows[i]) begin
      @(posedge sys_clk_i);
      mode <= rows[i].m;
      wr({4'h0, rows[i].w}, 20);
      chk(obs, rows[i].e);
    end
    wr(24'h080005, 20);
    chk(obs, 20'h07001);
    wr(24'h0c0000, 20);
    chk(obs, 20'h07001);
    wr(24'hf00205, 24);
    chk(obs, 20'h04a08);
    steps(4, n);
    chk(20'(n), 20'h2);
    chk({14'h0, sdir, mult}, 20'h30);
    wr(24'h000100, 20);
    steps(4, n);
    chk(20'(n), 20'h4);
    chk(20'(mult), 20'h1);
    @(posedge sys_clk_i);
    mode <= 1'b1;
    steps(4, n);
    chk(20'(n), 20'h0);
    chk(obs, 20'h00100);
    // A reset in mid-run clears the word and sets the multiplier back to 1, then a new word lands.
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    mode <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(negedge sys_clk_i);
    chk(obs, 20'h00100);
    chk(20'(mult), 20'h1);
    wr(24'h000004, 20);
    chk(obs, 20'h00810);
    final_report();
  end
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
